// File: design/cfih_pkg.sv
`default_nettype none
package cfih_pkg;
  localparam int DATA_W = 20; // channel sample width
  localparam int COEF_W = 20; // coefficient width
  localparam int HB_W = 22; // half-band sample width
  localparam int ADDR_W = 6; // coefficient address width
  localparam int RAM_DEPTH = 64; // coefficient entries
  localparam int TAP_W = 7; // tap count minus one
  localparam int MAX_TAPS = 128; // symmetric tap limit
  localparam int RATE_W = 4; // decimation rate and phase width
  localparam int ACC_W = 48; // tap accumulator width
  localparam int COEF_FRAC = 19; // coefficient binary point
  localparam int SCALE_MAX = 3; // code for 0 dB, each step down is 6.02 dB
  localparam int HB_FRAC = 9; // 512 is unity gain
  localparam int HB_SUM_W = 36; // half-band sum width
  localparam logic signed [10:0] HB_C1 = 11'h00E; // +14, taps 1 and 11
  localparam logic signed [10:0] HB_C3 = 11'h7BE; // -66, taps 3 and 9
  localparam logic signed [10:0] HB_C5 = 11'h135; // +309, taps 5 and 7
  localparam logic signed [10:0] HB_C6 = 11'h200; // +512, tap 6
  typedef enum logic [1:0] {CFIH_IDLE, CFIH_RUN, CFIH_EMIT} cfih_state_t;
endpackage
`default_nettype wire

// File: design/cfih_link_if.sv
`default_nettype none
interface cfih_link_if;
  logic coef_wr;
  logic coef_rd;
  logic coef_load;
  logic [cfih_pkg::ADDR_W-1:0] coef_start;
  logic [cfih_pkg::ADDR_W-1:0] coef_stop;
  logic [cfih_pkg::COEF_W-1:0] coef_wdata;
  logic [cfih_pkg::COEF_W-1:0] coef_rdata;
  logic [cfih_pkg::ADDR_W-1:0] eng_addr;
  logic [cfih_pkg::COEF_W-1:0] eng_coef;
  logic chan_valid;
  logic [cfih_pkg::HB_W-1:0] chan_i;
  logic [cfih_pkg::HB_W-1:0] chan_q;
  modport ram_side (
    input coef_wr, coef_rd, coef_load, coef_start, coef_stop, coef_wdata, eng_addr,
    output coef_rdata, eng_coef
  );
  modport hb_side (
    input chan_valid, chan_i, chan_q
  );
endinterface
`default_nettype wire

// File: design/cfih_coef_ram.sv
`default_nettype none
module cfih_coef_ram (
  input wire logic clock, // processing clock
  input wire logic reset_n, // async reset, active low
  cfih_link_if.ram_side link // host access and engine read
);
  logic [cfih_pkg::COEF_W-1:0] mem [cfih_pkg::RAM_DEPTH];
  logic [cfih_pkg::ADDR_W-1:0] ptr;
  logic [cfih_pkg::ADDR_W-1:0] next_ptr;
  logic [cfih_pkg::COEF_W-1:0] rdata;
  logic [cfih_pkg::COEF_W-1:0] next_rdata;
  logic access;

  // every read or write moves the pointer; load takes priority
  assign access = (link.coef_wr | link.coef_rd) & ~link.coef_load;
  assign link.eng_coef = mem[link.eng_addr];
  assign link.coef_rdata = rdata;

  // pointer walks start..stop, then wraps back to start
  always_comb
  begin
    next_ptr = ptr;
    next_rdata = rdata;
    if (link.coef_load)
      next_ptr = link.coef_start;
    else if (access)
      next_ptr = (ptr == link.coef_stop) ? link.coef_start : ptr + 6'h01;
    if (access && link.coef_rd)
      next_rdata = mem[ptr];
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ptr <= '0;
      rdata <= '0;
    end
    else
    begin
      ptr <= next_ptr;
      rdata <= next_rdata;
    end
  end

  // storage has no reset, software loads it before use
  always_ff @(posedge clock)
  begin
    if (access && link.coef_wr)
      mem[ptr] <= link.coef_wdata;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  ptr_wrap_a: assert property (access && ptr == link.coef_stop |=> ptr == $past(link.coef_start))
    else $error("pointer did not wrap at stop");
  write_land_a: assert property (access && link.coef_wr |=> mem[$past(ptr)] == $past(link.coef_wdata))
    else $error("coefficient write lost");
endmodule // cfih_coef_ram
`default_nettype wire

// File: design/cfih_halfband.sv
`default_nettype none
module cfih_halfband (
  input wire logic clock, // processing clock
  input wire logic reset_n, // async reset, active low
  input wire logic enable, // interpolate when high
  cfih_link_if.hb_side link, // channel filter samples
  output logic out_valid, // output sample strobe
  output logic [cfih_pkg::HB_W-1:0] out_i, // output I
  output logic [cfih_pkg::HB_W-1:0] out_q // output Q
);
  typedef logic signed [cfih_pkg::HB_W-1:0] cfih_smp_t;
  cfih_smp_t line_i [5];
  cfih_smp_t line_q [5];
  cfih_smp_t next_line_i [5];
  cfih_smp_t next_line_q [5];
  cfih_smp_t hold_i, hold_q, next_hold_i, next_hold_q, next_out_i, next_out_q;
  logic pend, next_pend, next_out_valid;

  // odd-phase taps, pre-adding the symmetric pairs
  function automatic cfih_smp_t odd_phase(input cfih_smp_t x, input cfih_smp_t l [5]);
    logic signed [cfih_pkg::HB_SUM_W-1:0] s;
    s = 36'(cfih_pkg::HB_C1 * (23'(x) + 23'(l[4])))
      + 36'(cfih_pkg::HB_C3 * (23'(l[0]) + 23'(l[3])))
      + 36'(cfih_pkg::HB_C5 * (23'(l[1]) + 23'(l[2])));
    return hb_round(s);
  endfunction

  // round half up, then saturate to the sample width
  function automatic cfih_smp_t hb_round(input logic signed [cfih_pkg::HB_SUM_W-1:0] s);
    logic signed [cfih_pkg::HB_SUM_W-1:0] r;
    r = (s + (36'sh1 <<< (cfih_pkg::HB_FRAC - 1))) >>> cfih_pkg::HB_FRAC;
    if (&r[35:21] || ~|r[35:21])
      return r[21:0];
    return {r[35], {21{~r[35]}}};
  endfunction

  // each input yields the centre-tap sample, then the odd-phase one next cycle
  always_comb
  begin
    next_line_i = line_i;
    next_line_q = line_q;
    next_hold_i = hold_i;
    next_hold_q = hold_q;
    next_pend = 1'b0;
    next_out_valid = pend;
    next_out_i = pend ? hold_i : out_i;
    next_out_q = pend ? hold_q : out_q;
    if (link.chan_valid && !enable)
    begin
      next_out_valid = 1'b1;
      next_out_i = link.chan_i;
      next_out_q = link.chan_q;
    end
    else if (link.chan_valid)
    begin
      next_line_i = '{link.chan_i, line_i[0], line_i[1], line_i[2], line_i[3]};
      next_line_q = '{link.chan_q, line_q[0], line_q[1], line_q[2], line_q[3]};
      next_out_valid = 1'b1;
      next_out_i = hb_round(36'(cfih_pkg::HB_C6 * line_i[2]));
      next_out_q = hb_round(36'(cfih_pkg::HB_C6 * line_q[2]));
      next_hold_i = odd_phase(link.chan_i, line_i);
      next_hold_q = odd_phase(link.chan_q, line_q);
      next_pend = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      line_i <= '{default: '0};
      line_q <= '{default: '0};
      hold_i <= '0;
      hold_q <= '0;
      pend <= 1'b0;
      out_valid <= 1'b0;
      out_i <= '0;
      out_q <= '0;
    end
    else
    begin
      line_i <= next_line_i;
      line_q <= next_line_q;
      hold_i <= next_hold_i;
      hold_q <= next_hold_q;
      pend <= next_pend;
      out_valid <= next_out_valid;
      out_i <= next_out_i;
      out_q <= next_out_q;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence two_beats;
    out_valid ##1 out_valid;
  endsequence
  hb_pair_a: assert property (enable && link.chan_valid |=> two_beats)
    else $error("interpolation did not give two samples");
  hb_center_a: assert property (enable && link.chan_valid |=> out_i == $past(line_i[2]))
    else $error("centre tap output wrong");
  hb_pass_a: assert property (!enable && link.chan_valid |=> out_valid && out_i == $past(link.chan_i))
    else $error("disabled stage did not pass sample");
endmodule // cfih_halfband
`default_nettype wire

// File: design/cfih_channel_filter.sv
// How it works
// - bypass set: input goes straight to the half-band, unscaled
// - 2-bit scale: 00 -18.06 dB, 01 -12.04, 10 -6.02, 11 0 dB
// - symmetry set: 64-entry RAM holds half of up to 128 taps
// - offset change mid-sample takes effect from the next sample
// - 4-bit decimation phase picks which input starts an output
// - one output per decimation-rate inputs
// - one tap per clock on each of I and Q
// - each coefficient access advances the pointer from start to stop
// - start equal to stop gives single-location writes
// - half-band takes 22-bit samples, gives rounded 22-bit samples
// - half-band taps +14, -66, +309, +512 mirrored, others zero
// - half-band interpolates by two, removing the image
// - half-band enable bit turns on interpolation
// - 20-bit coefficients and input data, 22-bit output data
// - tap count holds taps minus one
// - decimation rate field holds rate minus one, 1 to 16
`default_nettype none
module cfih_channel_filter #(
  parameter int HIST_DEPTH = 256 // sample history, power of two
) (
  input wire logic clock, // 200 MHz processing clock
  input wire logic reset_n, // async reset, active low
  input wire logic bypass, // pass input unfiltered
  input wire logic [1:0] scale, // output scaling code
  input wire logic symmetric, // half impulse stored
  input wire logic [cfih_pkg::ADDR_W-1:0] coef_offset, // filter set base
  input wire logic [cfih_pkg::TAP_W-1:0] tap_count, // taps minus one
  input wire logic [cfih_pkg::RATE_W-1:0] channel_decimation_rate, // rate minus one
  input wire logic [cfih_pkg::RATE_W-1:0] decim_phase, // output phase
  input wire logic hb_enable, // main filter control bit 9
  input wire logic [cfih_pkg::ADDR_W-1:0] coef_start, // pointer start
  input wire logic [cfih_pkg::ADDR_W-1:0] coef_stop, // pointer stop
  input wire logic coef_load, // pulse: pointer to start
  input wire logic coef_wr, // pulse: write coefficient
  input wire logic coef_rd, // pulse: read coefficient
  input wire logic [cfih_pkg::COEF_W-1:0] coef_wdata, // write data
  output logic [cfih_pkg::COEF_W-1:0] coef_rdata, // read data
  input wire logic in_valid, // input sample strobe
  input wire logic [cfih_pkg::DATA_W-1:0] in_i, // input I
  input wire logic [cfih_pkg::DATA_W-1:0] in_q, // input Q
  output logic out_valid, // output strobe
  output logic [cfih_pkg::HB_W-1:0] out_i, // output I
  output logic [cfih_pkg::HB_W-1:0] out_q, // output Q
  output logic calc_busy // tap engine running
);
  localparam int HIST_AW = $clog2(HIST_DEPTH);
  localparam int ACC_W = cfih_pkg::ACC_W;
  localparam int DATA_W = cfih_pkg::DATA_W;

  // twice the tap limit keeps new samples off the ones being read
  if (HIST_DEPTH < 2 * cfih_pkg::MAX_TAPS || (HIST_DEPTH & (HIST_DEPTH - 1)) != 0)
  begin : g_depth_check
    $error("history depth must be a power of two, at least twice the tap limit");
  end

  typedef logic signed [ACC_W-1:0] cfih_acc_t;
  typedef logic signed [DATA_W-1:0] cfih_data_t;

  cfih_link_if link ();

  cfih_pkg::cfih_state_t state, next_state;
  logic [2*DATA_W-1:0] hist [HIST_DEPTH];
  logic [HIST_AW-1:0] wr_ptr, next_wr_ptr;
  logic [HIST_AW-1:0] base_ptr, next_base_ptr;
  logic [HIST_AW-1:0] rd_idx;
  logic [cfih_pkg::RATE_W-1:0] phase_cnt, next_phase_cnt;
  logic [cfih_pkg::ADDR_W-1:0] cur_offset, next_offset;
  logic [cfih_pkg::TAP_W-1:0] cur_taps, next_taps;
  logic [cfih_pkg::TAP_W-1:0] tap_idx, next_tap_idx;
  logic cur_sym, next_sym;
  cfih_acc_t acc_i, acc_q, next_acc_i, next_acc_q;
  cfih_data_t tap_i, tap_q;
  logic signed [2*DATA_W-1:0] mul_i, mul_q;
  logic chan_valid, next_chan_valid;
  cfih_data_t chan_i, chan_q, next_chan_i, next_chan_q;
  logic next_busy;
  logic start;

  // engine address: RAM index for the j-th tap of the current set
  function automatic logic [cfih_pkg::ADDR_W-1:0] coef_addr(
    input logic [cfih_pkg::ADDR_W-1:0] offset,
    input logic [cfih_pkg::TAP_W-1:0] taps_m1,
    input logic sym,
    input logic [cfih_pkg::TAP_W-1:0] j
  );
    logic [cfih_pkg::TAP_W-1:0] k;
    logic [cfih_pkg::TAP_W-1:0] far;
    logic [cfih_pkg::TAP_W-1:0] half;
    k = taps_m1 - j;
    // symmetric: tap j and tap N-1-j fold onto one entry, the middle one at offset
    far = (k > j) ? k : j; // mirror onto the stored half
    half = 7'(({1'b0, taps_m1} + 8'h01) >> 1);
    if (sym)
      return offset + 6'(far - half);
    return offset + 6'(j); // reverse-loaded set: j-th entry meets j-th oldest sample
  endfunction

  // drop the coefficient point, apply the scale step, saturate
  function automatic cfih_data_t scale_sat(input cfih_acc_t acc, input logic [1:0] code);
    cfih_acc_t s;
    s = acc >>> (cfih_pkg::COEF_FRAC + cfih_pkg::SCALE_MAX - int'(code));
    if (&s[ACC_W-1:DATA_W-1] || ~|s[ACC_W-1:DATA_W-1])
      return s[DATA_W-1:0];
    return {s[ACC_W-1], {(DATA_W - 1){~s[ACC_W-1]}}};
  endfunction

  // host port into the coefficient store
  assign link.coef_wr = coef_wr;
  assign link.coef_rd = coef_rd;
  assign link.coef_load = coef_load;
  assign link.coef_start = coef_start;
  assign link.coef_stop = coef_stop;
  assign link.coef_wdata = coef_wdata;
  assign coef_rdata = link.coef_rdata;

  // channel output, left-justified into the wider half-band word
  assign link.chan_valid = chan_valid;
  assign link.chan_i = {chan_i, 2'h0};
  assign link.chan_q = {chan_q, 2'h0};

  cfih_coef_ram u_ram (
    .clock(clock),
    .reset_n(reset_n),
    .link(link.ram_side)
  );

  cfih_halfband u_hb (
    .clock(clock),
    .reset_n(reset_n),
    .enable(hb_enable),
    .link(link.hb_side),
    .out_valid(out_valid),
    .out_i(out_i),
    .out_q(out_q)
  );

  // tap read: oldest sample first, stepping toward the newest
  assign rd_idx = base_ptr - HIST_AW'(cur_taps - tap_idx);
  assign tap_i = hist[rd_idx][2*DATA_W-1:DATA_W];
  assign tap_q = hist[rd_idx][DATA_W-1:0];
  assign link.eng_addr = coef_addr(cur_offset, cur_taps, cur_sym, tap_idx);
  assign mul_i = signed'(link.eng_coef) * tap_i;
  assign mul_q = signed'(link.eng_coef) * tap_q;

  // a busy engine skips a start: too many taps for the output rate
  // limitation: that output is simply lost, so the host must size taps for the rate
  assign start = in_valid && !bypass && state == cfih_pkg::CFIH_IDLE
    && phase_cnt == decim_phase;

  // every sample enters history; no reset, it is overwritten before use
  // flops, not a RAM: one write and one tap read land in the same cycle
  always_ff @(posedge clock)
  begin
    if (in_valid)
      hist[wr_ptr] <= {in_i, in_q};
  end

  // decimation count, tap engine and output register
  always_comb
  begin
    next_state = state;
    next_wr_ptr = wr_ptr;
    next_base_ptr = base_ptr;
    next_phase_cnt = phase_cnt;
    next_offset = cur_offset;
    next_taps = cur_taps;
    next_sym = cur_sym;
    next_tap_idx = tap_idx;
    next_acc_i = acc_i;
    next_acc_q = acc_q;
    next_chan_valid = 1'b0;
    next_chan_i = chan_i;
    next_chan_q = chan_q;
    if (in_valid)
    begin
      next_wr_ptr = wr_ptr + 1'b1;
      if (phase_cnt >= channel_decimation_rate)
        next_phase_cnt = '0;
      else
        next_phase_cnt = phase_cnt + 4'h1;
    end
    unique case (state)
      cfih_pkg::CFIH_IDLE:
      begin
        if (start)
        begin
          // offset, tap count and symmetry are frozen for the whole sample
          next_offset = coef_offset;
          next_taps = tap_count;
          next_sym = symmetric;
          next_base_ptr = wr_ptr;
          next_tap_idx = '0;
          next_acc_i = '0;
          next_acc_q = '0;
          next_state = cfih_pkg::CFIH_RUN;
        end
      end
      cfih_pkg::CFIH_RUN:
      begin
        // both multipliers take one tap per clock
        next_acc_i = acc_i + ACC_W'(mul_i);
        next_acc_q = acc_q + ACC_W'(mul_q);
        next_tap_idx = tap_idx + 7'h01;
        if (tap_idx == cur_taps)
          next_state = cfih_pkg::CFIH_EMIT;
      end
      cfih_pkg::CFIH_EMIT:
      begin
        next_chan_valid = 1'b1;
        next_chan_i = scale_sat(acc_i, scale);
        next_chan_q = scale_sat(acc_q, scale);
        next_state = cfih_pkg::CFIH_IDLE;
      end
    endcase
    // bypass wins: every input sample goes out unchanged and unscaled
    if (bypass)
    begin
      next_chan_valid = in_valid;
      next_chan_i = in_i;
      next_chan_q = in_q;
    end
    next_busy = next_state != cfih_pkg::CFIH_IDLE;
  end

  // settings copied at start keep a set stable while it is used
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= cfih_pkg::CFIH_IDLE;
      wr_ptr <= '0;
      base_ptr <= '0;
      phase_cnt <= '0;
      cur_offset <= '0;
      cur_taps <= '0;
      cur_sym <= 1'b0;
      tap_idx <= '0;
      acc_i <= '0;
      acc_q <= '0;
      chan_valid <= 1'b0;
      chan_i <= '0;
      chan_q <= '0;
      calc_busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      wr_ptr <= next_wr_ptr;
      base_ptr <= next_base_ptr;
      phase_cnt <= next_phase_cnt;
      cur_offset <= next_offset;
      cur_taps <= next_taps;
      cur_sym <= next_sym;
      tap_idx <= next_tap_idx;
      acc_i <= next_acc_i;
      acc_q <= next_acc_q;
      chan_valid <= next_chan_valid;
      chan_i <= next_chan_i;
      chan_q <= next_chan_q;
      calc_busy <= next_busy;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence last_tap;
    state == cfih_pkg::CFIH_RUN && tap_idx == cur_taps;
  endsequence
  sequence emit_out;
    state == cfih_pkg::CFIH_EMIT ##1 chan_valid;
  endsequence

  bypass_pass_a: assert property (bypass && in_valid |=> chan_valid && chan_i == $past(in_i))
    else $error("bypass did not pass input");
  offset_hold_a: assert property (state == cfih_pkg::CFIH_RUN |=> cur_offset == $past(cur_offset))
    else $error("offset changed inside a sample");
  phase_start_a: assert property (start |=> state == cfih_pkg::CFIH_RUN && tap_idx == 7'h00)
    else $error("engine did not start on phase");
  decim_wrap_a: assert property (in_valid && phase_cnt >= channel_decimation_rate |=> phase_cnt == 4'h0)
    else $error("decimation count did not wrap");
  tap_step_a: assert property (state == cfih_pkg::CFIH_RUN && tap_idx != cur_taps |=> tap_idx == $past(tap_idx) + 7'h01)
    else $error("tap engine skipped a cycle");
  tap_end_a: assert property (last_tap and !bypass |=> emit_out)
    else $error("output not issued after last tap");
  idle_quiet_a: assert property (!bypass && state != cfih_pkg::CFIH_EMIT |=> !chan_valid)
    else $error("output outside the emit step");

  // engine activity flag and the symmetric fold
  busy_track_a: assert property (start |=> calc_busy)
    else $error("busy flag missing while engine runs");
  busy_drop_a: assert property (state == cfih_pkg::CFIH_EMIT |=> !calc_busy)
    else $error("busy flag stuck after output");
  sym_mirror_a: assert property (state == cfih_pkg::CFIH_RUN && cur_sym
    |-> link.eng_addr == coef_addr(cur_offset, cur_taps, 1'b1, cur_taps - tap_idx))
    else $error("symmetric taps did not share a coefficient");
endmodule // cfih_channel_filter
`default_nettype wire

// File: sim/cfih_src_model.sv
`default_nettype none
// upstream filter stand-in: one sample strobe per request
module cfih_src_model (
  input wire logic clock, // processing clock
  input wire logic go, // request one sample
  input wire logic [cfih_pkg::DATA_W-1:0] x, // sample for I, Q gets its negation
  output logic in_valid, // sample strobe
  output logic [cfih_pkg::DATA_W-1:0] in_i, // I data
  output logic [cfih_pkg::DATA_W-1:0] in_q // Q data
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle data shows the inverse of the last request, so a stale sample never matches
  // requests come well apart, far below the half-band input limit
  always @(posedge clock)
  begin
    in_valid <= go;
    in_i <= go ? x : ~x;
    in_q <= go ? 20'h00000 - x : ~(20'h00000 - x);
  end
endmodule // cfih_src_model
`default_nettype wire

// File: sim/channel_fir_and_interp_halfband_tb_top.sv
`default_nettype none
module channel_fir_and_interp_halfband_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic byp;
    logic sym;
    logic [5:0] off;
    logic [1:0] scl;
    logic [19:0] x;
    logic [21:0] e;
  } cfih_row_t;
  logic clock, reset_n, bypass, symmetric, hb_enable, coef_load, coef_wr, coef_rd;
  logic in_valid, out_valid, calc_busy, go;
  logic [1:0] scale;
  logic [5:0] coef_offset, coef_start, coef_stop;
  logic [6:0] tap_count;
  logic [3:0] channel_decimation_rate, decim_phase;
  logic [19:0] coef_wdata, coef_rdata, in_i, in_q, x;
  logic [21:0] out_i, out_q;
  int n_errors, comparisons, n_out;
  // ram: [0]=0.25 [1]=0.5 [8]=0.5 [9]=0.5; constant input 0x400, 0xFFFFD in the bypass row
  cfih_row_t rows [8] = '{
    '{1'b0, 1'b0, 6'h00, 2'h3, 20'h00400, 22'h000C00},
    '{1'b0, 1'b0, 6'h00, 2'h2, 20'h00400, 22'h000600},
    '{1'b0, 1'b0, 6'h00, 2'h1, 20'h00400, 22'h000300},
    '{1'b0, 1'b0, 6'h00, 2'h0, 20'h00400, 22'h000180},
    '{1'b0, 1'b0, 6'h08, 2'h3, 20'h00400, 22'h001000},
    '{1'b0, 1'b1, 6'h00, 2'h3, 20'h00400, 22'h000800},
    '{1'b0, 1'b1, 6'h08, 2'h3, 20'h00400, 22'h001000},
    '{1'b1, 1'b0, 6'h00, 2'h0, 20'hFFFFD, 22'h3FFFF4}};

  cfih_channel_filter #(.HIST_DEPTH(256)) dut_u (.clock, .reset_n, .bypass, .scale,
    .symmetric, .coef_offset, .tap_count, .channel_decimation_rate, .decim_phase,
    .hb_enable, .coef_start, .coef_stop, .coef_load, .coef_wr, .coef_rd, .coef_wdata,
    .coef_rdata, .in_valid, .in_i, .in_q, .out_valid, .out_i, .out_q, .calc_busy);
  cfih_src_model src_u (.clock, .go, .x, .in_valid, .in_i, .in_q);

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // counts output strobes for the decimation checks
  always @(posedge clock)
  begin
    if (out_valid === 1'b1)
      n_out++;
  end
  task chk(input string what, input logic [21:0] e, input logic [21:0] s);
  begin
    comparisons++;
    if (s !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  end
  endtask
  // coefficient port access, one strobe per word; full 20-bit words only
  task cop(input logic ld, input logic wr, input logic [19:0] d);
  begin
    @(posedge clock);
    coef_load <= ld;
    coef_wr <= wr;
    coef_rd <= !ld && !wr;
    coef_wdata <= d;
    @(posedge clock);
    coef_load <= 1'b0;
    coef_wr <= 1'b0;
    coef_rd <= 1'b0;
    @(posedge clock);
    #1;
  end
  endtask
  task rng(input logic [5:0] s, input logic [5:0] t);
  begin
    @(posedge clock);
    coef_start <= s;
    coef_stop <= t;
    cop(1'b1, 1'b0, 20'h00000);
  end
  endtask
  // one sample; latency counted in cycles from the input strobe to the output strobe
  task send(input logic [19:0] v, input bit ck, input logic [21:0] e, input int lat);
    int n;
  begin
    n = 0;
    @(posedge clock);
    go <= 1'b1;
    x <= v;
    @(posedge clock);
    go <= 1'b0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end while (out_valid !== 1'b1 && n < 40);
    if (ck)
    begin
      chk("out_i", e, out_i);
      chk("out_q", 22'h000000 - e, out_q);
      chk("latency", lat[21:0], n[21:0]);
    end
  end
  endtask
  task done(input string name);
    $display("test %s finished", name);
  endtask
  task summarize;
  begin
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  // watchdog, well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clock);
    n_errors++;
    summarize();
  end

  initial
  begin
    {reset_n, bypass, symmetric, hb_enable, coef_load, coef_wr, coef_rd, go} = 8'h00;
    {scale, coef_offset, coef_start, coef_stop, decim_phase} = 24'h000000;
    channel_decimation_rate = 4'h0;
    tap_count = 7'h01; // two taps, within both mode limits
    coef_wdata = 20'h00000;
    x = 20'h00000;
    n_errors = 0;
    comparisons = 0;
    n_out = 0;
    repeat (3) @(posedge clock);
    #1;
    chk("reset out_i", 22'h000000, out_i);
    chk("reset valid", 22'h000000, {21'h0, out_valid});
    chk("reset busy", 22'h000000, {21'h0, calc_busy});
    @(posedge clock);
    reset_n <= 1'b1;
    done("reset");
    // asymmetric sets at 0 and 8, last coefficient first
    rng(6'h00, 6'h01);
    cop(1'b0, 1'b1, 20'h20000);
    cop(1'b0, 1'b1, 20'h40000);
    rng(6'h08, 6'h09);
    cop(1'b0, 1'b1, 20'h40000);
    cop(1'b0, 1'b1, 20'h40000);
    rng(6'h00, 6'h01);
    cop(1'b0, 1'b0, 20'h00000);
    chk("rd0", 22'h020000, {2'b00, coef_rdata});
    cop(1'b0, 1'b0, 20'h00000);
    chk("rd1", 22'h040000, {2'b00, coef_rdata});
    cop(1'b0, 1'b0, 20'h00000);
    chk("rd wrap", 22'h020000, {2'b00, coef_rdata});
    // one location: the second write lands on the same place
    rng(6'h05, 6'h05);
    cop(1'b0, 1'b1, 20'h12345);
    cop(1'b0, 1'b1, 20'h0ABCD);
    rng(6'h05, 6'h05);
    cop(1'b0, 1'b0, 20'h00000);
    chk("single", 22'h00ABCD, {2'b00, coef_rdata});
    done("coefficients");
    foreach (rows[k])
    begin
      @(posedge clock);
      bypass <= rows[k].byp;
      symmetric <= rows[k].sym;
      coef_offset <= rows[k].off;
      scale <= rows[k].scl;
      send(rows[k].x, 1'b0, 22'h000000, 0);
      send(rows[k].x, 1'b1, rows[k].e, rows[k].byp ? 2 : 5);
    end
    done("table");
    // offset moved during a computation: old set now, new set next
    @(posedge clock);
    {bypass, symmetric, coef_offset, scale} <= {2'b00, 6'h00, 2'h3};
    send(20'h00400, 1'b0, 22'h000000, 0);
    fork
      send(20'h00400, 1'b1, 22'h000C00, 5);
      begin
        repeat (4) @(posedge clock);
        coef_offset <= 6'h08;
        #1;
        chk("busy", 22'h000001, {21'h0, calc_busy});
      end
    join
    send(20'h00400, 1'b1, 22'h001000, 5);
    done("offset");
    // rate 2: phase 1 gives two outputs of four inputs, phase 2 none
    for (int p = 1; p < 3; p++)
    begin
      @(posedge clock);
      channel_decimation_rate <= 4'h1;
      decim_phase <= p[3:0];
      #1;
      n_out = 0;
      repeat (4) send(20'h00400, 1'b0, 22'h000000, 0);
      @(posedge clock);
      #1;
      chk("outputs", p == 1 ? 22'h000002 : 22'h000000, n_out[21:0]);
    end
    done("decimation");
    @(posedge clock);
    {channel_decimation_rate, decim_phase, bypass, hb_enable} <= {8'h00, 2'b11};
    repeat (6) send(20'h00100, 1'b0, 22'h000000, 0);
    send(20'h00100, 1'b1, 22'h000400, 2);
    @(posedge clock);
    #1;
    chk("second valid", 22'h000001, {21'h0, out_valid});
    chk("second i", 22'h000404, out_i);
    done("halfband");
    summarize();
  end
endmodule // channel_fir_and_interp_halfband_tb_top
`default_nettype wire
